// ==== rtl/mvs_pkg.sv ====
// Purpose: Shared constants and types for the media-valid strap logic
// Assumes: APB slave with 12-bit byte address and 32-bit data
// Notes: Register byte address is four times the register index

package mvs_pkg;

  // ------------------------------------------------------------------
  // Bus widths
  // ------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ------------------------------------------------------------------
  // Register indices and byte addresses
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] TAPE_IDX = 12'h3f3;
  localparam logic [ADDR_W-1:0] FCR_IDX = 12'h3f4;
  localparam logic [ADDR_W-1:0] DSEL_IDX = 12'h3f5;
  localparam logic [ADDR_W-1:0] STRAP_IDX = 12'h3f6;
  localparam logic [ADDR_W-1:0] TAPE_ADDR = ADDR_W'(TAPE_IDX << 2);
  localparam logic [ADDR_W-1:0] FCR_ADDR = ADDR_W'(FCR_IDX << 2);
  localparam logic [ADDR_W-1:0] DSEL_ADDR = ADDR_W'(DSEL_IDX << 2);
  localparam logic [ADDR_W-1:0] STRAP_ADDR = ADDR_W'(STRAP_IDX << 2);

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int TAPE_SEL_LSB = 0;
  localparam int TAPE_VALID_BIT = 5;
  localparam int TAPE_MID_LSB = 6;
  localparam int FCR_SENSE_BIT = 0;
  localparam logic [7:0] FCR_RESET = 8'h00;
  localparam logic [1:0] TAPE_SEL_RESET = 2'h0;
  localparam logic [1:0] DSEL_RESET = 2'h0;
  localparam logic [1:0] STRAP_LEVEL_RESET = 2'h0;
  localparam logic TAPE_FIXED_BIT5 = 1'b1;

  // ------------------------------------------------------------------
  // Timing: cycles the strap is sampled after reset release
  // ------------------------------------------------------------------
  localparam int STRAP_SETTLE_CYCLES = 4;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } mvs_apb_req_type;

  typedef enum logic {
    CAP_WAIT = 1'b0,
    CAP_DONE = 1'b1
  } mvs_cap_state_type;

endpackage : mvs_pkg

// ==== rtl/mvs_strap_capture.sv ====
// Purpose: Capture the two media-valid straps around reset release
// Assumes: Straps are static board levels while reset is applied
// Notes: Pins pass two flip-flops before the capture register reads them
`timescale 1ns/10ps

module mvs_strap_capture #(
  parameter int SETTLE = mvs_pkg::STRAP_SETTLE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] strap_n_pin,
  output logic [1:0] strap_level,
  output logic capture_done,
  output logic load_pulse
);
  import mvs_pkg::*;

  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [1:0] level_reg;
  logic [1:0] level_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic load_reg;
  logic load_next;
  mvs_cap_state_type state_reg;
  mvs_cap_state_type state_next;

  // ------------------------------------------------------------------
  // Capture sequence
  // ------------------------------------------------------------------
  // Sampling continues a few cycles past release so the synchroniser
  // has flushed reset-time zeros before the level is frozen
  always_comb begin
    level_next = level_reg;
    cnt_next = cnt_reg;
    load_next = 1'b0;
    state_next = state_reg;
    unique case (state_reg)
      CAP_WAIT: begin
        level_next = sync2_reg;
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg == 8'(SETTLE - 1)) begin
          state_next = CAP_DONE;
          load_next = 1'b1;
        end
      end
      CAP_DONE: begin
        level_next = level_reg;
      end
    endcase
  end

  // Two-stage synchroniser plus capture state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= STRAP_LEVEL_RESET;
      sync2_reg <= STRAP_LEVEL_RESET;
      level_reg <= STRAP_LEVEL_RESET;
      cnt_reg <= 8'h00;
      load_reg <= 1'b0;
      state_reg <= CAP_WAIT;
    end else begin
      sync1_reg <= strap_n_pin;
      sync2_reg <= sync1_reg;
      level_reg <= level_next;
      cnt_reg <= cnt_next;
      load_reg <= load_next;
      state_reg <= state_next;
    end
  end

  assign strap_level = level_reg;
  assign capture_done = (state_reg == CAP_DONE);
  assign load_pulse = load_reg;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_level_held;
    (state_reg == CAP_DONE) |=> $stable(level_reg);
  endproperty
  a_level_held: assert property (p_level_held)
    else $error("Captured strap level changed after capture");

  property p_done_on_time;
    (state_reg == CAP_WAIT) && (cnt_reg == 8'(SETTLE - 1))
      |=> capture_done && load_pulse ##1 !load_pulse;
  endproperty
  a_done_on_time: assert property (p_done_on_time)
    else $error("Strap capture did not finish on the expected cycle");

  c_capture: cover property (load_pulse);

endmodule : mvs_strap_capture

// ==== rtl/mvs_media_valid.sv ====
// Purpose: APB register view of the media-valid straps and function control
// Assumes: Single 100 MHz clock, asynchronous active-low reset
// Notes: Accesses stall with pready low until the strap capture completes
`timescale 1ns/10ps

// Functional notes
// - Both media-valid straps are sampled around reset and held until the next reset.
// - A low drive-0 strap makes tape bit 5 read 0 when drive 0 is selected.
// - A high drive-0 strap makes tape bit 5 read 1 when drive 0 is selected.
// - The drive-1 strap sets tape bit 5 the same way when drive 1 is selected.
// - The captured drive-0 strap level is loaded into function control bit 0.
// - With function control bit 0 set, the strap levels no longer mean media-valid.
module mvs_media_valid (
  input wire logic pclk,
  input wire logic presetn,
  input wire mvs_pkg::mvs_apb_req_type apb_req,
  output logic [mvs_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic drive0_media_valid_strap_n,
  input wire logic drive1_media_valid_strap_n,
  input wire logic [1:0] media_id_pin,
  output logic media_sense_mode,
  output logic strap_capture_done
);
  import mvs_pkg::*;

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [1:0] strap_level;
  logic capture_done;
  logic load_pulse;
  logic [1:0] mid_sync1_reg;
  logic [1:0] mid_sync2_reg;
  logic [7:0] function_control_reg;
  logic [7:0] function_control_next;
  logic [1:0] tape_sel_reg;
  logic [1:0] tape_sel_next;
  logic [1:0] dsel_reg;
  logic [1:0] dsel_next;
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic done_reg;
  logic access;
  logic take;
  logic commit;
  logic hit;
  logic [7:0] rd_byte;

  // ------------------------------------------------------------------
  // Strap capture
  // ------------------------------------------------------------------
  mvs_strap_capture #(
    .SETTLE(STRAP_SETTLE_CYCLES)
  ) u_capture (
    .pclk(pclk),
    .presetn(presetn),
    .strap_n_pin({drive1_media_valid_strap_n, drive0_media_valid_strap_n}),
    .strap_level(strap_level),
    .capture_done(capture_done),
    .load_pulse(load_pulse)
  );

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Valid flag seen by software for the selected drive
  function automatic logic valid_flag(input logic [1:0] lvl, input logic [1:0] sel,
                                      input logic sense);
    logic f;
    f = TAPE_FIXED_BIT5;
    if (sense) begin
      f = TAPE_FIXED_BIT5;
    end else if (sel == 2'h0) begin
      f = lvl[0];
    end else if (sel == 2'h1) begin
      f = lvl[1];
    end
    return f;
  endfunction : valid_flag

  // Address decode of the four word registers
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    return (a == TAPE_ADDR) || (a == FCR_ADDR) || (a == DSEL_ADDR) || (a == STRAP_ADDR);
  endfunction : addr_hit

  // ------------------------------------------------------------------
  // APB phase decode
  // ------------------------------------------------------------------
  // One wait state; held off entirely until straps are captured so no
  // read can return a half-settled valid flag
  assign access = apb_req.psel && apb_req.penable;
  assign take = access && !pready_reg && capture_done;
  assign commit = access && pready_reg;
  assign hit = addr_hit(apb_req.paddr);

  // Read byte mux
  always_comb begin
    rd_byte = 8'h00;
    if (apb_req.paddr == TAPE_ADDR) begin
      rd_byte[TAPE_SEL_LSB +: 2] = tape_sel_reg;
      rd_byte[TAPE_VALID_BIT] = valid_flag(strap_level, dsel_reg,
                                           function_control_reg[FCR_SENSE_BIT]);
      rd_byte[TAPE_MID_LSB +: 2] = mid_sync2_reg;
    end else if (apb_req.paddr == FCR_ADDR) begin
      rd_byte = function_control_reg;
    end else if (apb_req.paddr == DSEL_ADDR) begin
      rd_byte[1:0] = dsel_reg;
    end else if (apb_req.paddr == STRAP_ADDR) begin
      rd_byte[1:0] = strap_level;
    end
  end

  // Answer registers
  always_comb begin
    pready_next = take;
    pslverr_next = take && !hit;
    prdata_next = prdata_reg;
    if (take) begin
      prdata_next = apb_req.pwrite ? '0 : {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // ------------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------------
  // Strap load beats a software write landing in the same cycle
  always_comb begin
    function_control_next = function_control_reg;
    tape_sel_next = tape_sel_reg;
    dsel_next = dsel_reg;
    if (commit && apb_req.pwrite) begin
      if (apb_req.paddr == FCR_ADDR) begin
        function_control_next = apb_req.pwdata[7:0];
      end
      if (apb_req.paddr == TAPE_ADDR) begin
        tape_sel_next = apb_req.pwdata[TAPE_SEL_LSB +: 2];
      end
      if (apb_req.paddr == DSEL_ADDR) begin
        dsel_next = apb_req.pwdata[1:0];
      end
    end
    if (load_pulse) begin
      function_control_next[FCR_SENSE_BIT] = strap_level[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      function_control_reg <= FCR_RESET;
      tape_sel_reg <= TAPE_SEL_RESET;
      dsel_reg <= DSEL_RESET;
      mid_sync1_reg <= 2'h0;
      mid_sync2_reg <= 2'h0;
      done_reg <= 1'b0;
    end else begin
      function_control_reg <= function_control_next;
      tape_sel_reg <= tape_sel_next;
      dsel_reg <= dsel_next;
      mid_sync1_reg <= media_id_pin; // Media ID pins cross in here
      mid_sync2_reg <= mid_sync1_reg;
      done_reg <= capture_done;
    end
  end

  // Outputs straight from flip-flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign media_sense_mode = function_control_reg[FCR_SENSE_BIT];
  assign strap_capture_done = done_reg;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic rd_tape;
  assign rd_tape = take && !apb_req.pwrite && (apb_req.paddr == TAPE_ADDR);

  property p_d0_low;
    rd_tape && !function_control_reg[0] && dsel_reg == 2'h0 && !strap_level[0]
      |=> pready && !prdata[5];
  endproperty
  a_d0_low: assert property (p_d0_low)
    else $error("Drive 0 low strap did not read as valid");

  property p_d0_high;
    rd_tape && !function_control_reg[0] && dsel_reg == 2'h0 && strap_level[0]
      |=> pready && prdata[5];
  endproperty
  a_d0_high: assert property (p_d0_high)
    else $error("Drive 0 high strap did not read as invalid");

  property p_d1;
    rd_tape && !function_control_reg[0] && dsel_reg == 2'h1
      |=> prdata[5] == $past(strap_level[1]);
  endproperty
  a_d1: assert property (p_d1)
    else $error("Drive 1 strap not reflected in bit 5");

  property p_fcr_load;
    load_pulse |=> function_control_reg[0] == $past(strap_level[0])
      && media_sense_mode == $past(strap_level[0]);
  endproperty
  a_fcr_load: assert property (p_fcr_load)
    else $error("Function control bit 0 not loaded from drive 0 strap");

  property p_fixed;
    rd_tape && function_control_reg[0] |=> prdata[5] == TAPE_FIXED_BIT5;
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("Bit 5 not fixed while function control bit 0 is set");

  property p_no_early;
    !capture_done |-> ##1 !pready;
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("Answer given before strap capture completed");

  c_read_d0: cover property (rd_tape && dsel_reg == 2'h0 ##1 pready);
  c_read_d1: cover property (rd_tape && dsel_reg == 2'h1 ##1 pready);
  c_unmapped: cover property (pslverr);

endmodule : mvs_media_valid

// ==== verification/mvs_board_model.sv ====
// Purpose: Board straps and media ID lines seen by the media-valid block
// Assumes: Straps are resistors, so they hold their level through each reset
// Notes: A low strap means media ID is valid for that drive
`timescale 1ns/10ps

module mvs_board_model (
  input wire logic [1:0] strap_high,
  input wire logic [1:0] mid_set,
  output logic drive0_media_valid_strap_n,
  output logic drive1_media_valid_strap_n,
  output logic [1:0] media_id_pin
);
  // ------------------------------------------------------------------
  // Pin levels
  // ------------------------------------------------------------------
  // External pull-up wins over the internal pull-down; otherwise the pin sits low
  assign drive0_media_valid_strap_n = strap_high[0];
  assign drive1_media_valid_strap_n = strap_high[1];
  assign media_id_pin = mid_set;
endmodule : mvs_board_model

// ==== verification/mvs_media_valid_tb.sv ====
// Purpose: Self-checking bench for the media-valid register view
// Assumes: APB master changes signals by non-blocking assignment at rising edges
// Notes: Each strap combination needs its own hardware reset
`timescale 1ns/10ps

module mvs_media_valid_tb;
  import mvs_pkg::*;

  logic pclk;
  logic presetn;
  mvs_apb_req_type req;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic s0_n;
  logic s1_n;
  logic [1:0] mid;
  logic [1:0] mid_set;
  logic [1:0] strap_high;
  logic sense;
  logic done;
  logic [31:0] rd;
  logic err;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;

  // ------------------------------------------------------------------
  // Clock and watchdog
  // ------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Ceiling far above the hundred or so cycles the sequence needs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      test_done();
    end
  end

  mvs_media_valid mvs_media_valid_inst (
    .pclk(pclk),
    .presetn(presetn),
    .apb_req(req),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .drive0_media_valid_strap_n(s0_n),
    .drive1_media_valid_strap_n(s1_n),
    .media_id_pin(mid),
    .media_sense_mode(sense),
    .strap_capture_done(done)
  );

  mvs_board_model mvs_board_model_inst (
    .strap_high(strap_high),
    .mid_set(mid_set),
    .drive0_media_valid_strap_n(s0_n),
    .drive1_media_valid_strap_n(s1_n),
    .media_id_pin(mid)
  );

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One APB transfer; waits on pready, the watchdog ends a hang
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr, input logic [31:0] wd);
    @(posedge pclk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= addr;
    req.pwdata <= wd;
    @(posedge pclk);
    req.penable <= 1'b1;
    // Sample pready at the rising edge, the same edge at which the slave commits
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask : rd_chk

  // Straps only matter around reset, so each setting gets a full reset
  task automatic boot(input logic [1:0] lv, input logic [1:0] m);
    @(posedge pclk);
    presetn <= 1'b0;
    strap_high <= lv;
    mid_set <= m;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask : boot

  task automatic test_done();
    if (bad_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    req = '0;
    strap_high = 2'h2;
    mid_set = 2'h2;
    // Drive 0 valid, drive 1 not valid
    boot(2'h2, 2'h2);
    check("done", {31'h0, done}, 32'h1);
    check("sense", {31'h0, sense}, 32'h0);
    rd_chk("fcr", FCR_ADDR, 32'h00);
    strap_high <= 2'h1;
    rd_chk("tape d0", TAPE_ADDR, 32'h80);
    apb(1'b1, STRAP_ADDR, 32'h3);
    rd_chk("strap", STRAP_ADDR, 32'h2);
    apb(1'b1, DSEL_ADDR, 32'h1);
    rd_chk("tape d1", TAPE_ADDR, 32'ha0);
    apb(1'b1, DSEL_ADDR, 32'h0);
    apb(1'b1, FCR_ADDR, 32'h1);
    // The write lands at the edge the task returns on; look one edge later
    @(posedge pclk);
    check("sense", {31'h0, sense}, 32'h1);
    rd_chk("tape fcr", TAPE_ADDR, 32'ha0);
    apb(1'b1, 12'h010, 32'hff);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    // Drive 0 not valid, drive 1 valid
    boot(2'h1, 2'h1);
    check("sense", {31'h0, sense}, 32'h1);
    rd_chk("fcr", FCR_ADDR, 32'h01);
    rd_chk("tape d0", TAPE_ADDR, 32'h60);
    apb(1'b1, DSEL_ADDR, 32'h1);
    rd_chk("tape d1 fcr", TAPE_ADDR, 32'h60);
    apb(1'b1, FCR_ADDR, 32'h0);
    rd_chk("tape d1", TAPE_ADDR, 32'h40);
    apb(1'b1, DSEL_ADDR, 32'h0);
    rd_chk("tape d0 again", TAPE_ADDR, 32'h60);
    rd_chk("strap", STRAP_ADDR, 32'h1);
    test_done();
  end
endmodule : mvs_media_valid_tb
